// ==== verilog/vcp_defines.svh ====
`ifndef VCP_DEFINES_SVH
`define VCP_DEFINES_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define VCP_HYB_ADDR 7'h0B
`define VCP_HYB_RESET 8'h03
`define VCP_HYB_BAL_MSB 2
`define VCP_HYB_BAL_LSB 0
`define VCP_HYB_DIS_BIT 3

// -----------------------------------------------------------------------------
// Datapath constants
// -----------------------------------------------------------------------------
`define VCP_GAIN_SHIFT 6
`define VCP_GAIN_MAX 8'h80
`define VCP_HPF_SHIFT 4
`define VCP_BAL_SHIFT 8
`define VCP_MU_CLIP 16'h7F7B
`define VCP_MU_BIAS 16'h0084
`define VCP_A_MASK 8'h55
`define VCP_A_KNEE 16'h0100
`define VCP_SLOT_BITS 5'h08
`define VCP_WORD_BITS 5'h10

`endif

// ==== verilog/vcp_pkg.sv ====
package vcp_pkg;

	// Loopback selection; one value means at most one mode is ever active.
	typedef enum logic [2:0] {
		VCP_LOOP_NONE,
		VCP_LOOP_FULL_ANALOG,
		VCP_LOOP_PARTIAL_ANALOG,
		VCP_LOOP_FULL_DIGITAL,
		VCP_LOOP_PARTIAL_DIGITAL
	} vcp_loop_t;

	// Analog amplifier gain steps, in rising order.
	typedef enum logic [1:0] {
		VCP_AGAIN_MUTE,
		VCP_AGAIN_M3P5,
		VCP_AGAIN_0DB,
		VCP_AGAIN_P3P5
	} vcp_again_t;

endpackage : vcp_pkg

// ==== verilog/vcp_datapath.sv ====
// Function
// - One 16-bit signed transmit sample enters per 8 kHz frame.
// - A digital high-pass stage precedes the transmit gain.
// - Transmit digital gain spans mute up to +6 dB.
// - Last transmit step optionally compresses to 8 bits, A-law or mu-law.
// - Compressed word uses one slot; linear word spans two consecutive slots.
// - Received 8-bit codes expand to 16-bit linear with the selected law.
// - Linear format skips expansion and joins two slot bytes.
// - Receive gain mute to +6 dB, one sample per frame to the DAC.
// - Each analog amplifier has mute, -3.5, 0 or +3.5 dB select.
// - Balance subtracts scaled receive signal, nominal -6 dB, 3-bit adjust.
// - Balance subtraction happens before any transmit gain stage.
// - A setting disables balance subtraction entirely.
// - Full analog loopback feeds transmit code into the receive expander.
// - Partial analog loopback sends ADC samples straight to the DAC.
// - Full digital loopback returns receive output to transmit via hybrid path.
// - Partial digital loopback feeds DAC input into transmit filter.
// - Digital loopbacks still honour the linear format bypass.
// - Compressor clips at its maximum code for oversized inputs.
`include "vcp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module vcp_datapath #(
	parameter int HPF_STAGES = 2
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic signed [15:0] adc_data_i,
	input wire logic adc_valid_i,
	output logic signed [15:0] dac_data_o,
	output logic dac_valid_o,
	input wire logic [7:0] tx_digital_gain_i,
	input wire logic [7:0] rx_digital_gain_i,
	input wire logic tx_highpass_stage_i,
	input wire logic linear_format_bypass_i,
	input wire logic a_law_i,
	input wire vcp_pkg::vcp_loop_t loop_mode_i,
	input wire vcp_pkg::vcp_again_t tx_analog_gain_select_i,
	input wire vcp_pkg::vcp_again_t rx_analog_gain_select_i,
	output vcp_pkg::vcp_again_t tx_analog_gain_select_o,
	output vcp_pkg::vcp_again_t rx_analog_gain_select_o,
	input wire logic pcm_clk_i,
	input wire logic frame_sync_i,
	input wire logic pcm_rx_i,
	output logic pcm_tx_o,
	output logic pcm_tx_oe_o
);

	// Refuse section counts that the cascade below is not sized for.
	if (HPF_STAGES < 1 || HPF_STAGES > 4) begin : g_bad_hpf_stages
		$error("HPF_STAGES must lie between 1 and 4.");
	end

	// -------------------------------------------------------------------------
	// Arithmetic helpers
	// -------------------------------------------------------------------------

	// Clamp a wide signed value into 16 bits.
	function automatic logic signed [15:0] vcp_sat(input logic signed [24:0] v);
		if (v > 25'sh0007FFF) begin
			return 16'sh7FFF;
		end else if (v < -25'sh0008000) begin
			return -16'sh8000;
		end else begin
			return v[15:0];
		end
	endfunction : vcp_sat

	// Gain word is Q2.6: 8'h40 is unity, 8'h80 is +6 dB, 8'h00 mutes.
	function automatic logic signed [15:0] vcp_gain(input logic signed [15:0] x,
		input logic [7:0] g);
		logic [7:0] gc;
		logic signed [24:0] p;
		gc = (g > `VCP_GAIN_MAX) ? `VCP_GAIN_MAX : g;
		p = x * $signed({1'b0, gc});
		return vcp_sat(p >>> `VCP_GAIN_SHIFT);
	endfunction : vcp_gain

	// Balance coefficient in Q0.8; code 3 is the nominal half (-6 dB).
	function automatic logic [8:0] vcp_bal_coef(input logic [2:0] c);
		case (c)
			3'h0: return 9'h05D;
			3'h1: return 9'h067;
			3'h2: return 9'h073;
			3'h3: return 9'h080;
			3'h4: return 9'h08F;
			3'h5: return 9'h0A0;
			3'h6: return 9'h0B4;
			default: return 9'h0CD;
		endcase
	endfunction : vcp_bal_coef

	function automatic logic signed [15:0] vcp_scale(input logic signed [15:0] x,
		input logic [2:0] c);
		logic signed [24:0] p;
		p = x * $signed({1'b0, vcp_bal_coef(c)});
		return vcp_sat(p >>> `VCP_BAL_SHIFT);
	endfunction : vcp_scale

	// Segmented mu-law encoder with the customary full inversion.
	function automatic logic [7:0] vcp_mu_enc(input logic signed [15:0] x);
		logic [15:0] mag;
		logic [2:0] ex;
		mag = x[15] ? 16'(-x) : 16'(x);
		if (mag > `VCP_MU_CLIP) begin
			mag = `VCP_MU_CLIP;
		end
		mag = mag + `VCP_MU_BIAS;
		ex = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (mag[i + 7]) begin
				ex = 3'(i);
			end
		end
		// The shift count is widened so the top segments do not wrap.
		return ~{x[15], ex, 4'(mag >> ({1'b0, ex} + 4'h3))};
	endfunction : vcp_mu_enc

	function automatic logic signed [15:0] vcp_mu_dec(input logic [7:0] code);
		logic [7:0] c;
		logic [15:0] t;
		c = ~code;
		t = ({9'h000, c[3:0], 3'h0} + `VCP_MU_BIAS) << c[6:4];
		return c[7] ? $signed(`VCP_MU_BIAS - t) : $signed(t - `VCP_MU_BIAS);
	endfunction : vcp_mu_dec

	// Segmented A-law encoder with alternate-bit inversion.
	function automatic logic [7:0] vcp_a_enc(input logic signed [15:0] x);
		logic [15:0] mag;
		logic [2:0] ex;
		mag = x[15] ? 16'(~x) : 16'(x);
		ex = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (mag[i + 7]) begin
				ex = 3'(i);
			end
		end
		if (ex == 3'h0) begin
			return {~x[15], ex, 4'(mag >> 4)} ^ `VCP_A_MASK;
		end
		return {~x[15], ex, 4'(mag >> ({1'b0, ex} + 4'h3))} ^ `VCP_A_MASK;
	endfunction : vcp_a_enc

	function automatic logic signed [15:0] vcp_a_dec(input logic [7:0] code);
		logic [7:0] c;
		logic [15:0] t;
		c = code ^ `VCP_A_MASK;
		t = {8'h00, c[3:0], 4'h8};
		if (c[6:4] != 3'h0) begin
			t = (t + `VCP_A_KNEE) << (c[6:4] - 3'h1);
		end
		return c[7] ? $signed(t) : $signed(16'(-t));
	endfunction : vcp_a_dec

	// -------------------------------------------------------------------------
	// Control register and loop decode
	// -------------------------------------------------------------------------
	logic [7:0] hybrid_balance_control;
	wire hyb_sel = (reg_addr_i == `VCP_HYB_ADDR);
	wire [2:0] balance_gain_field = hybrid_balance_control[`VCP_HYB_BAL_MSB:`VCP_HYB_BAL_LSB];
	wire balance_off = hybrid_balance_control[`VCP_HYB_DIS_BIT];
	wire frame_tick = ce_i && adc_valid_i;
	wire lp_full_an = (loop_mode_i == vcp_pkg::VCP_LOOP_FULL_ANALOG);
	wire lp_part_an = (loop_mode_i == vcp_pkg::VCP_LOOP_PARTIAL_ANALOG);
	wire lp_full_dg = (loop_mode_i == vcp_pkg::VCP_LOOP_FULL_DIGITAL);
	wire lp_part_dg = (loop_mode_i == vcp_pkg::VCP_LOOP_PARTIAL_DIGITAL);

	// Register write, registered read-back; unmapped addresses read zero.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			hybrid_balance_control <= `VCP_HYB_RESET;
			reg_rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (reg_wr_i && hyb_sel) begin
				hybrid_balance_control <= reg_wdata_i;
			end
			reg_rdata_o <= hyb_sel ? hybrid_balance_control : 8'h00;
		end
	end

	// Analog amplifier selects are only forwarded; the amplifiers are outside.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tx_analog_gain_select_o <= vcp_pkg::VCP_AGAIN_0DB;
			rx_analog_gain_select_o <= vcp_pkg::VCP_AGAIN_0DB;
		end else if (ce_i) begin
			tx_analog_gain_select_o <= tx_analog_gain_select_i;
			rx_analog_gain_select_o <= rx_analog_gain_select_i;
		end
	end

	// -------------------------------------------------------------------------
	// Transmit chain: source, balance, high-pass, gain, compression
	// -------------------------------------------------------------------------
	// Subtraction sits ahead of the transmit digital gain so gain changes never upset balance.
	wire signed [15:0] bal_term = balance_off ? 16'sh0000 :
		vcp_scale(dac_data_o, balance_gain_field);
	wire signed [24:0] tx_diff = 25'(adc_data_i) - 25'(bal_term);
	wire signed [15:0] tx_hyb = lp_part_dg ? dac_data_o :
		lp_full_dg ? vcp_scale(dac_data_o, balance_gain_field) :
		vcp_sat(tx_diff);
	logic signed [15:0] hp_sig [0:HPF_STAGES];
	assign hp_sig[0] = tx_hyb;

	// First-order DC-blocking sections in cascade; more sections sharpen the skirt.
	for (genvar s = 0; s < HPF_STAGES; s++) begin : g_hpf
		logic signed [15:0] x1;
		logic signed [24:0] y1;
		wire signed [24:0] y = 25'(hp_sig[s]) - 25'(x1) + y1 - (y1 >>> `VCP_HPF_SHIFT);
		assign hp_sig[s + 1] = vcp_sat(y);
		always_ff @(posedge ref_clk_i) begin
			if (!rst_n_i) begin
				x1 <= 16'sh0000;
				y1 <= 25'sh0000000;
			end else if (frame_tick) begin
				x1 <= hp_sig[s];
				y1 <= 25'(hp_sig[s + 1]);
			end
		end
	end

	wire signed [15:0] tx_hp = tx_highpass_stage_i ? hp_sig[HPF_STAGES] : tx_hyb;
	wire signed [15:0] tx_amp = vcp_gain(tx_hp, tx_digital_gain_i);
	wire [7:0] tx_code = a_law_i ? vcp_a_enc(tx_amp) : vcp_mu_enc(tx_amp);
	wire [15:0] next_tx_word = linear_format_bypass_i ? tx_amp : {8'h00, tx_code};

	// -------------------------------------------------------------------------
	// Receive chain: source, expansion, gain
	// -------------------------------------------------------------------------
	logic [15:0] tx_word;
	logic tx_lin;
	logic tx_tog;
	logic [15:0] rx_word;
	wire [15:0] rx_src = lp_full_an ? tx_word : rx_word;
	wire signed [15:0] rx_exp = a_law_i ? vcp_a_dec(rx_src[7:0]) :
		vcp_mu_dec(rx_src[7:0]);
	wire signed [15:0] rx_lin = linear_format_bypass_i ? rx_src : rx_exp;
	wire signed [15:0] next_dac = lp_part_an ? adc_data_i :
		vcp_gain(rx_lin, rx_digital_gain_i);

	// Per frame: latch the highway word, post it to the link, update the DAC.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tx_word <= 16'h0000;
			tx_lin <= 1'b0;
			tx_tog <= 1'b0;
			dac_data_o <= 16'sh0000;
			dac_valid_o <= 1'b0;
		end else if (ce_i) begin
			dac_valid_o <= adc_valid_i;
			if (adc_valid_i) begin
				tx_word <= next_tx_word;
				tx_lin <= linear_format_bypass_i;
				tx_tog <= ~tx_tog;
				dac_data_o <= next_dac;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Crossing from the link: toggle plus stable word
	// -------------------------------------------------------------------------
	// The word stays still for a whole frame, far longer than the sync delay.
	logic [15:0] rx_word_l;
	logic rx_tog_l;
	logic rs1;
	logic rs2;
	logic rs3;
	logic racc;
	wire rx_evt = (rs2 == rs3) && (rs3 != racc);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rs1 <= 1'b0;
			rs2 <= 1'b0;
			rs3 <= 1'b0;
			racc <= 1'b0;
			rx_word <= 16'h0000;
		end else if (ce_i) begin
			rs1 <= rx_tog_l;
			rs2 <= rs1;
			rs3 <= rs2;
			if (rx_evt) begin
				racc <= rs3;
				rx_word <= rx_word_l;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Link domain on the highway bit clock
	// -------------------------------------------------------------------------
	logic [1:0] lrst;
	wire lrst_n = lrst[1];
	logic ts1;
	logic ts2;
	logic ts3;
	logic tacc;
	logic [15:0] tx_hold;
	logic hold_lin;
	logic [15:0] tx_sh;
	logic [4:0] tx_left;
	logic [15:0] rx_sh;
	logic [4:0] rx_left;
	logic rx_lin_l;
	wire tx_evt = (ts2 == ts3) && (ts3 != tacc);
	wire [4:0] len = hold_lin ? `VCP_WORD_BITS : `VCP_SLOT_BITS;
	wire [15:0] tx_load = hold_lin ? tx_hold : {tx_hold[7:0], 8'h00};

	// Reset release and word handover into the bit clock domain.
	always_ff @(posedge pcm_clk_i) begin
		lrst <= {lrst[0], rst_n_i};
		if (!lrst_n) begin
			ts1 <= 1'b0;
			ts2 <= 1'b0;
			ts3 <= 1'b0;
			tacc <= 1'b0;
			tx_hold <= 16'h0000;
			hold_lin <= 1'b0;
		end else begin
			ts1 <= tx_tog;
			ts2 <= ts1;
			ts3 <= ts2;
			if (tx_evt) begin
				tacc <= ts3;
				tx_hold <= tx_word;
				hold_lin <= tx_lin;
			end
		end
	end

	// Serial shifter, MSB first; a linear word fills two back-to-back slots.
	always_ff @(posedge pcm_clk_i) begin
		if (!lrst_n) begin
			tx_sh <= 16'h0000;
			tx_left <= 5'h00;
			pcm_tx_o <= 1'b0;
			pcm_tx_oe_o <= 1'b0;
		end else if (frame_sync_i) begin
			pcm_tx_o <= tx_load[15];
			pcm_tx_oe_o <= 1'b1;
			tx_sh <= {tx_load[14:0], 1'b0};
			tx_left <= len - 5'h01;
		end else if (tx_left != 5'h00) begin
			pcm_tx_o <= tx_sh[15];
			tx_sh <= {tx_sh[14:0], 1'b0};
			tx_left <= tx_left - 5'h01;
		end else begin
			pcm_tx_oe_o <= 1'b0;
		end
	end

	// Receive slots are sampled on the edges after frame sync, MSB first.
	always_ff @(posedge pcm_clk_i) begin
		if (!lrst_n) begin
			rx_sh <= 16'h0000;
			rx_left <= 5'h00;
			rx_lin_l <= 1'b0;
			rx_word_l <= 16'h0000;
			rx_tog_l <= 1'b0;
		end else if (frame_sync_i) begin
			rx_left <= len;
			rx_lin_l <= hold_lin;
		end else if (rx_left != 5'h00) begin
			rx_sh <= {rx_sh[14:0], pcm_rx_i};
			rx_left <= rx_left - 5'h01;
			if (rx_left == 5'h01) begin
				rx_word_l <= rx_lin_l ? {rx_sh[14:0], pcm_rx_i} :
					{8'h00, rx_sh[6:0], pcm_rx_i};
				rx_tog_l <= ~rx_tog_l;
			end
		end
	end

endmodule : vcp_datapath

`default_nettype wire

// ==== bench/vcp_datapath_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vcp_defines.svh"
// ----------------------------------------
// Port checks of the voice datapath
// ----------------------------------------
module vcp_datapath_props (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic signed [15:0] adc_data_i,
	input wire logic adc_valid_i,
	input wire logic signed [15:0] dac_data_o,
	input wire logic dac_valid_o,
	input wire vcp_pkg::vcp_loop_t loop_mode_i,
	input wire vcp_pkg::vcp_again_t tx_analog_gain_select_i,
	input wire vcp_pkg::vcp_again_t tx_analog_gain_select_o,
	input wire logic pcm_clk_i,
	input wire logic frame_sync_i,
	input wire logic pcm_tx_oe_o
);
	// Frame strobe, loopback data and the hold of the sample between frames.
	AST_DAC_VALID: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ce_i && adc_valid_i |=> dac_valid_o) else $error("dac strobe missing");
	AST_LOOP_ADC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ce_i && adc_valid_i && loop_mode_i == vcp_pkg::VCP_LOOP_PARTIAL_ANALOG
		|=> dac_data_o == $past(adc_data_i)) else $error("loop sample wrong");
	AST_DAC_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!dac_valid_o |-> $stable(dac_data_o)) else $error("dac moved between frames");
	// Register map: a single location, everything else reads as zero; analog gain select forwarding.
	AST_REG_OTHER: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ce_i && reg_addr_i != `VCP_HYB_ADDR |=> reg_rdata_o == 8'h00) else $error("bad read");
	AST_REG_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ce_i && reg_wr_i && reg_addr_i == `VCP_HYB_ADDR ##1
		ce_i && !reg_wr_i && reg_addr_i == `VCP_HYB_ADDR
		|=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("write lost");
	AST_GAIN_SEL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ce_i |=> tx_analog_gain_select_o == $past(tx_analog_gain_select_i))
		else $error("gain select stale");
	// Highway drive window opens on the sync edge and lasts a whole slot.
	AST_OE_START: assert property (@(posedge pcm_clk_i) disable iff (!rst_n_i)
		frame_sync_i |=> pcm_tx_oe_o) else $error("slot not driven");
	AST_OE_LEN: assert property (@(posedge pcm_clk_i) disable iff (!rst_n_i)
		$rose(pcm_tx_oe_o) |-> pcm_tx_oe_o [*8]) else $error("slot cut short");
endmodule : vcp_datapath_props

bind vcp_datapath vcp_datapath_props u_vcp_datapath_props (
	.ref_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
	.adc_data_i, .adc_valid_i, .dac_data_o, .dac_valid_o, .loop_mode_i,
	.tx_analog_gain_select_i, .tx_analog_gain_select_o,
	.pcm_clk_i, .frame_sync_i, .pcm_tx_oe_o
);
`default_nettype wire

// ==== bench/vcp_pcm_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Highway master model
// ----------------------------------------
module vcp_pcm_master (
	output logic pcm_clk_o,
	output logic frame_sync_o,
	output logic pcm_rx_o,
	input wire logic pcm_tx_i
);
	// The bit clock runs free, since the device derives its timing from it.
	initial begin
		pcm_clk_o = 1'b0;
		frame_sync_o = 1'b0;
		pcm_rx_o = 1'b0;
		#1.3;
		forever #3 pcm_clk_o = ~pcm_clk_o;
	end

	// One frame: a sync pulse, then n bits each way, MSB first.
	task automatic exchange(input logic [15:0] w, input int n, output logic [15:0] got);
		got = 16'h0000;
		@(posedge pcm_clk_o);
		frame_sync_o <= 1'b1;
		@(posedge pcm_clk_o);
		frame_sync_o <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			pcm_rx_o <= w[i];
			@(negedge pcm_clk_o);
			got[i] = pcm_tx_i;
			@(posedge pcm_clk_o);
		end
		// A released line flips so a stale bit is never read as data.
		pcm_rx_o <= ~w[0];
	endtask : exchange
endmodule : vcp_pcm_master
`default_nettype wire

// ==== bench/vcp_datapath_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vcp_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
// ----------------------------------------
// Voice datapath testbench
// ----------------------------------------
module vcp_datapath_tb_top;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0;
	logic [6:0] reg_addr_i = 7'h00;
	logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
	logic [7:0] tx_digital_gain_i = 8'h40, rx_digital_gain_i = 8'h40;
	logic signed [15:0] adc_data_i = 16'h0000, dac_data_o;
	logic adc_valid_i = 1'b0, dac_valid_o, tx_highpass_stage_i = 1'b0;
	logic linear_format_bypass_i = 1'b0, a_law_i = 1'b0;
	logic pcm_clk_i, frame_sync_i, pcm_rx_i, pcm_tx_o, pcm_tx_oe_o;
	vcp_pkg::vcp_loop_t loop_mode_i = vcp_pkg::VCP_LOOP_NONE;
	vcp_pkg::vcp_again_t tx_analog_gain_select_i = vcp_pkg::VCP_AGAIN_0DB;
	vcp_pkg::vcp_again_t rx_analog_gain_select_i = vcp_pkg::VCP_AGAIN_0DB;
	vcp_pkg::vcp_again_t tx_analog_gain_select_o, rx_analog_gain_select_o;
	int n_errors = 0, comparisons = 0;
	logic [15:0] tx;

	// Core clock and the two parties around the datapath.
	always #20 ref_clk_i = ~ref_clk_i;
	vcp_datapath u_vcp_datapath (.ref_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i,
		.reg_wdata_i, .reg_rdata_o, .adc_data_i, .adc_valid_i, .dac_data_o, .dac_valid_o,
		.tx_digital_gain_i, .rx_digital_gain_i, .tx_highpass_stage_i,
		.linear_format_bypass_i, .a_law_i, .loop_mode_i, .tx_analog_gain_select_i,
		.rx_analog_gain_select_i, .tx_analog_gain_select_o, .rx_analog_gain_select_o,
		.pcm_clk_i, .frame_sync_i, .pcm_rx_i, .pcm_tx_o, .pcm_tx_oe_o);
	vcp_pcm_master u_vcp_pcm_master (.pcm_clk_o(pcm_clk_i), .frame_sync_o(frame_sync_i),
		.pcm_rx_o(pcm_rx_i), .pcm_tx_i(pcm_tx_o));

	// Verdict, register access and one frame of traffic.
	task automatic give_verdict();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_write
	task automatic reg_check(input logic [6:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		`CHK(reg_rdata_o, e)
	endtask : reg_check
	// The word sent in one frame is the sample taken in the frame before.
	task automatic xfer(input logic [15:0] rx, adc, edac, input logic chk);
		int k;
		repeat (4) @(posedge ref_clk_i);
		u_vcp_pcm_master.exchange(rx, linear_format_bypass_i ? 16 : 8, tx);
		repeat (8) @(posedge ref_clk_i);
		adc_data_i <= adc;
		adc_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		adc_valid_i <= 1'b0;
		for (k = 0; k < 4; k++) begin
			@(negedge ref_clk_i);
			if (dac_valid_o === 1'b1)
				break;
		end
		if (k == 4) begin
			n_errors++;
			$display("BAD %0t no dac strobe", $time);
			give_verdict();
		end
		if (chk)
			`CHK(dac_data_o, edac)
	endtask : xfer
	task automatic row(input logic law, input logic [15:0] adc, input logic [7:0] tg, rg, rc,
			etx, input logic [15:0] edac);
		@(posedge ref_clk_i);
		a_law_i <= law;
		tx_digital_gain_i <= tg;
		rx_digital_gain_i <= rg;
		xfer({8'h00, rc}, adc, edac, 1'b0);
		xfer({8'h00, rc}, adc, edac, 1'b1);
		`CHK(tx, {8'h00, etx})
	endtask : row

	// Main sequence.
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		reg_check(`VCP_HYB_ADDR, `VCP_HYB_RESET);
		reg_write(`VCP_HYB_ADDR, 8'h05);
		reg_check(`VCP_HYB_ADDR, 8'h05);
		reg_write(7'h2A, 8'hAA);
		reg_check(7'h2A, 8'h00);
		reg_write(`VCP_HYB_ADDR, 8'h0B);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			tx_analog_gain_select_i <= vcp_pkg::vcp_again_t'(i);
			rx_analog_gain_select_i <= vcp_pkg::vcp_again_t'(3 - i);
			@(posedge ref_clk_i);
			@(negedge ref_clk_i);
			`CHK(tx_analog_gain_select_o, vcp_pkg::vcp_again_t'(i))
			`CHK(rx_analog_gain_select_o, vcp_pkg::vcp_again_t'(3 - i))
		end
		$display("test gain selects done");
		@(posedge ref_clk_i);
		loop_mode_i <= vcp_pkg::VCP_LOOP_PARTIAL_ANALOG;
		rx_digital_gain_i <= 8'h00;
		xfer(16'h0000, 16'h8001, 16'h8001, 1'b1);
		@(posedge ref_clk_i);
		loop_mode_i <= vcp_pkg::VCP_LOOP_NONE;
		linear_format_bypass_i <= 1'b1;
		rx_digital_gain_i <= 8'h40;
		xfer(16'h1234, 16'h0ABC, 16'h0000, 1'b0);
		xfer(16'h1234, 16'h0ABC, 16'h1234, 1'b1);
		`CHK(tx, 16'h0ABC)
		@(posedge ref_clk_i);
		rx_digital_gain_i <= 8'hFF;
		xfer(16'h1234, 16'h0ABC, 16'h2468, 1'b1);
		@(posedge ref_clk_i);
		loop_mode_i <= vcp_pkg::VCP_LOOP_PARTIAL_DIGITAL;
		rx_digital_gain_i <= 8'h40;
		xfer(16'h1234, 16'h0000, 16'h1234, 1'b1);
		xfer(16'h1234, 16'h0000, 16'h1234, 1'b0);
		xfer(16'h1234, 16'h0000, 16'h1234, 1'b0);
		`CHK(tx, 16'h1234)
		$display("test linear and loopback done");
		@(posedge ref_clk_i);
		loop_mode_i <= vcp_pkg::VCP_LOOP_NONE;
		linear_format_bypass_i <= 1'b0;
		row(1'b0, 16'h0000, 8'h40, 8'h40, 8'h80, 8'hFF, 16'h7D7C);
		row(1'b0, 16'h7FFF, 8'h40, 8'h40, 8'h80, 8'h80, 16'h7D7C);
		row(1'b0, 16'h8000, 8'h40, 8'h00, 8'h80, 8'h00, 16'h0000);
		row(1'b0, 16'h7FFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 16'h0000);
		row(1'b1, 16'h7FFF, 8'h40, 8'h00, 8'hD5, 8'hAA, 16'h0000);
		row(1'b1, 16'h8000, 8'h40, 8'h00, 8'hD5, 8'h2A, 16'h0000);
		row(1'b1, 16'h0000, 8'h40, 8'h00, 8'hD5, 8'hD5, 16'h0000);
		$display("test companding done");
		// Balance on at the nominal half; the gain change must not upset it.
		reg_write(`VCP_HYB_ADDR, 8'h03);
		@(posedge ref_clk_i);
		linear_format_bypass_i <= 1'b1;
		rx_digital_gain_i <= 8'h40;
		xfer(16'h1000, 16'h2000, 16'h0000, 1'b0);
		xfer(16'h1000, 16'h2000, 16'h1000, 1'b1);
		@(posedge ref_clk_i);
		tx_digital_gain_i <= 8'h80;
		xfer(16'h1000, 16'h2000, 16'h1000, 1'b1);
		`CHK(tx, 16'h1FF8)
		xfer(16'h1000, 16'h2000, 16'h1000, 1'b0);
		`CHK(tx, 16'h3000)
		@(posedge ref_clk_i);
		loop_mode_i <= vcp_pkg::VCP_LOOP_FULL_DIGITAL;
		tx_digital_gain_i <= 8'h40;
		xfer(16'h1000, 16'h2000, 16'h1000, 1'b0);
		xfer(16'h1000, 16'h2000, 16'h1000, 1'b0);
		`CHK(tx, 16'h0800)
		reg_write(`VCP_HYB_ADDR, 8'h0B);
		@(posedge ref_clk_i);
		loop_mode_i <= vcp_pkg::VCP_LOOP_FULL_ANALOG;
		linear_format_bypass_i <= 1'b0;
		a_law_i <= 1'b0;
		xfer(16'h00FF, 16'h7FFF, 16'h7D7C, 1'b0);
		xfer(16'h00FF, 16'h7FFF, 16'h7D7C, 1'b1);
		$display("test balance and loops done");
		give_verdict();
	end
endmodule : vcp_datapath_tb_top
`default_nettype wire
